// ---- common/gisc_pkg.sv ----
// Constants, types and register map of the group inhibit and shutdown block
package gisc_pkg;
   localparam int NUM_INT = 4;
   localparam int NUM_GRP = 4;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 8;
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int INH_LAT_NS = 10000;
   localparam int MAINS_LAT_NS = 1000000;
   localparam int CROW_PULSE_NS = 1000000;
   localparam int INH_LAT_CYC = INH_LAT_NS / CLK_PERIOD_NS;
   localparam int MAINS_LAT_CYC = MAINS_LAT_NS / CLK_PERIOD_NS;
   localparam int CROW_PULSE_CYC =
      (CROW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Register offsets
   localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
   localparam logic [ADDR_W-1:0] MODE_OFF = 8'h04;
   localparam logic [ADDR_W-1:0] MAP_OFF = 8'h08;
   localparam logic [ADDR_W-1:0] CMD_OFF = 8'h0c;
   localparam logic [ADDR_W-1:0] PSTAT_OFF = 8'h10;
   localparam logic [ADDR_W-1:0] STAT_OFF = 8'h14;
   // Control fields and reset values
   localparam int CTRL_AUTO = 0;
   localparam int CTRL_FE = 1;
   localparam int CTRL_CROW = 2;
   localparam logic [2:0] CTRL_RST = 3'h2;
   localparam logic [NUM_INT-1:0] MODE_RST = 4'h0;
   localparam logic [15:0] MAP_RST = 16'h0000;
   // Command fields
   localparam int CMD_ON_LSB = 0;
   localparam int CMD_OFF_LSB = 4;
   localparam int CMD_CROW_FIRE = 8;
   localparam int CMD_PROG_ALL = 9;
   // Status fields
   localparam int ST_ON_LSB = 0;
   localparam int ST_FORCE_LSB = 4;
   localparam int ST_PG_LSB = 8;
   localparam int ST_MAINS = 12;
   localparam int ST_BUSY = 13;
   localparam int ST_CROW = 14;
   localparam int ST_HR = 15;
   typedef enum logic {SEQ_IDLE, SEQ_PROG} gisc_seq_e;
endpackage : gisc_pkg

// ---- common/gisc_evt_if.sv ----
// Request and activity pair between the controller and its timers
`timescale 1ns/1ps
`default_nettype none
interface gisc_evt_if;
   logic req;
   logic act;
   modport ctl (output req, input act);
   modport unit (input req, output act);
endinterface : gisc_evt_if
`default_nettype wire

// ---- design/gisc_low_filter.sv ----
// Assertion delay: act follows req after CNT cycles, drops at once
`timescale 1ns/1ps
`default_nettype none
module gisc_low_filter
   import gisc_pkg::*;
#(
   parameter int CNT = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   gisc_evt_if.unit ev
);
   logic [CNT_W-1:0] cnt_r;
   logic act_r;

   // Count held request cycles, release clears immediately
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         act_r <= 1'b0;
      end else if (ce) begin
         if (!ev.req) begin
            cnt_r <= '0;
            act_r <= 1'b0;
         end else if (!act_r) begin
            if (cnt_r == CNT_W'(CNT - 1)) begin
               act_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   end

   assign ev.act = act_r;

   filt_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(act_r) |-> $past(ev.req) && cnt_r == CNT_W'(CNT - 1))
      else $error("filter asserted without full count");
endmodule : gisc_low_filter
`default_nettype wire

// ---- design/gisc_pulse_timer.sv ----
// Fixed-length pulse started by a request
`timescale 1ns/1ps
`default_nettype none
module gisc_pulse_timer
   import gisc_pkg::*;
#(
   parameter int CNT = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   gisc_evt_if.unit ev
);
   logic [CNT_W-1:0] cnt_r;
   logic act_r;

   // Load on request when idle, count down to end of pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         act_r <= 1'b0;
      end else if (ce) begin
         if (!act_r && ev.req) begin
            act_r <= 1'b1;
            cnt_r <= CNT_W'(CNT - 1);
         end else if (act_r) begin
            if (cnt_r == '0) begin
               act_r <= 1'b0;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end

   assign ev.act = act_r;

   pulse_end_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && act_r && cnt_r == '0 |=> !act_r)
      else $error("pulse did not end at zero count");
endmodule : gisc_pulse_timer
`default_nettype wire

// ---- design/gisc_top.sv ----
// Group inhibit, trigger, shutdown, front-end and crowbar controller
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module gisc_top
   import gisc_pkg::*;
#(
   parameter int MAINS_CYC = MAINS_LAT_CYC,
   parameter int CROW_CYC = CROW_PULSE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NUM_INT-1:0] interrupt_in_n,
   input wire logic mains_loss_in_n,
   input wire logic system_shutdown_in_n,
   input wire logic hard_reset_in_n,
   input wire logic [NUM_GRP-1:0] pg_in,
   output logic [NUM_GRP-1:0] pg_out,
   output logic [NUM_GRP-1:0] pg_oe_n,
   output logic prog_req_out,
   output logic [NUM_GRP-1:0] prog_grp_out,
   input wire logic prog_done_in,
   output logic nvm_store_out,
   input wire logic crowbar_event_in,
   output logic front_end_enable_out,
   output logic crowbar_trigger_out
);
   // Address match, used by both read and write decode
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   logic [2:0] ctrl_r;
   logic [NUM_INT-1:0] mode_r;
   logic [15:0] map_r;
   logic [NUM_GRP-1:0] pstat_r;
   logic [NUM_GRP-1:0] grp_on_r;
   logic [NUM_GRP-1:0] pend_r;
   logic [NUM_GRP-1:0] prog_grp_r;
   logic [NUM_GRP-1:0] pg_oe_n_r;
   logic [NUM_INT-1:0] int_act_d_r;
   logic mains_d_r;
   logic hr_d_r;
   logic nvm_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   gisc_seq_e seq_r;

   logic hr;
   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic [NUM_INT-1:0] int_act;
   logic [NUM_INT-1:0] trig_fall;
   logic [NUM_INT-1:0] trig_rise;
   logic mains_act;
   logic mains_fall;
   logic mains_rise;
   logic hr_rel;
   logic [NUM_GRP-1:0] inh_force;
   logic [NUM_GRP-1:0] force_nxt;
   logic [NUM_GRP-1:0] cmd_on;
   logic [NUM_GRP-1:0] cmd_off;
   logic cmd_prog_all;
   logic crow_fire;
   logic prog_done;
   logic [31:0] status;

   gisc_evt_if int_ev[NUM_INT] ();
   gisc_evt_if mains_ev ();
   gisc_evt_if crow_ev ();

   // Hard reset input acts as a synchronous reset of block state, except that a running crowbar pulse is not cut short
   assign hr = !hard_reset_in_n;

   // Inhibit latency filters, one per interrupt input
   generate
      for (genvar i = 0; i < NUM_INT; i++) begin : g_int
         assign int_ev[i].req = !interrupt_in_n[i] && !hr;
         assign int_act[i] = int_ev[i].act;
         gisc_low_filter #(.CNT(INH_LAT_CYC)) u_filt (
            .pclk(pclk),
            .presetn(presetn),
            .ce(pce),
            .ev(int_ev[i])
         );
      end
   endgenerate

   // Mains-loss and shutdown behave alike, merged before the filter
   assign mains_ev.req =
      (!mains_loss_in_n || !system_shutdown_in_n) && !hr;
   assign mains_act = mains_ev.act;
   gisc_low_filter #(.CNT(MAINS_CYC)) u_mains (
      .pclk(pclk),
      .presetn(presetn),
      .ce(pce),
      .ev(mains_ev)
   );

   // Crowbar pulse timer
   assign crow_ev.req = crow_fire && ctrl_r[CTRL_CROW];
   gisc_pulse_timer #(.CNT(CROW_CYC)) u_crow (
      .pclk(pclk),
      .presetn(presetn),
      .ce(pce),
      .ev(crow_ev)
   );

   // Edge detection of filtered inputs and of the unfiltered hard reset
   assign trig_fall = int_act & ~int_act_d_r & mode_r;
   assign trig_rise = ~int_act & int_act_d_r & mode_r;
   assign mains_fall = mains_act && !mains_d_r;
   assign mains_rise = !mains_act && mains_d_r;
   assign hr_rel = !hr && hr_d_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_act_d_r <= '0;
         mains_d_r <= 1'b0;
         hr_d_r <= 1'b0; // Idle level, no false release after reset
      end else if (pce) begin
         int_act_d_r <= int_act;
         mains_d_r <= mains_act;
         hr_d_r <= hr;
      end
   end

   // Inhibit map: inhibit-mode inputs force their mapped groups
   always_comb begin
      inh_force = '0;
      for (int i = 0; i < NUM_INT; i++) begin
         if (int_act[i] && !mode_r[i]) begin
            inh_force = inh_force | map_r[NUM_GRP*i +: NUM_GRP];
         end
      end
   end

   // All shutdown sources ORed per group
   assign force_nxt = inh_force | {NUM_GRP{mains_act}}
                      | {NUM_GRP{hr}} | ~grp_on_r;

   // Open-drain power-good drivers, enable low while pulling low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_oe_n_r <= '0;
      end else if (pce) begin
         pg_oe_n_r <= ~force_nxt;
      end
   end

   // APB decode, zero-wait access phase
   assign wr_en = psel && penable && pwrite && pce;
   assign rd_setup = psel && !penable && pce;
   assign mapped = hit(paddr, CTRL_OFF) || hit(paddr, MODE_OFF)
                   || hit(paddr, MAP_OFF) || hit(paddr, CMD_OFF)
                   || hit(paddr, PSTAT_OFF) || hit(paddr, STAT_OFF);
   assign cmd_on = (wr_en && hit(paddr, CMD_OFF) && !hr) ?
                   pwdata[CMD_ON_LSB +: NUM_GRP] : '0;
   assign cmd_off = (wr_en && hit(paddr, CMD_OFF) && !hr) ?
                    pwdata[CMD_OFF_LSB +: NUM_GRP] : '0;
   assign cmd_prog_all = wr_en && hit(paddr, CMD_OFF) && !hr
                         && pwdata[CMD_PROG_ALL];
   assign crow_fire = crowbar_event_in
                      || (wr_en && hit(paddr, CMD_OFF) && !hr
                          && pwdata[CMD_CROW_FIRE]);

   // Host-written configuration, lost under hard reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
         mode_r <= MODE_RST;
         map_r <= MAP_RST;
      end else if (pce) begin
         if (hr) begin
            ctrl_r <= CTRL_RST;
            mode_r <= MODE_RST;
            map_r <= MAP_RST;
         end else if (wr_en && hit(paddr, CTRL_OFF)) begin
            ctrl_r <= pwdata[2:0];
         end else if (wr_en && hit(paddr, MODE_OFF)) begin
            mode_r <= pwdata[NUM_INT-1:0];
         end else if (wr_en && hit(paddr, MAP_OFF)) begin
            map_r <= pwdata[15:0];
         end
      end
   end

   // Status word
   always_comb begin
      status = '0;
      status[ST_ON_LSB +: NUM_GRP] = grp_on_r;
      status[ST_FORCE_LSB +: NUM_GRP] = ~pg_oe_n_r;
      status[ST_PG_LSB +: NUM_GRP] = pg_in;
      status[ST_MAINS] = mains_act;
      status[ST_BUSY] = (seq_r == SEQ_PROG);
      status[ST_CROW] = crow_ev.act;
      status[ST_HR] = hr;
   end

   // Read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
         pslverr_r <= 1'b0;
      end else if (rd_setup) begin
         pslverr_r <= !mapped || hr;
         prdata_r <= '0;
         if (!pwrite) begin
            if (hit(paddr, CTRL_OFF)) prdata_r <= {29'h0, ctrl_r};
            if (hit(paddr, MODE_OFF)) prdata_r <= {28'h0, mode_r};
            if (hit(paddr, MAP_OFF)) prdata_r <= {16'h0, map_r};
            if (hit(paddr, PSTAT_OFF)) prdata_r <= {28'h0, pstat_r};
            if (hit(paddr, STAT_OFF)) prdata_r <= status;
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = psel && penable;
   assign pslverr = psel && penable && pslverr_r;

   // Programming sequencer towards the converters
   assign prog_done = (seq_r == SEQ_PROG) && prog_done_in;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_r <= SEQ_IDLE;
         prog_grp_r <= '0;
      end else if (pce) begin
         if (hr) begin
            seq_r <= SEQ_IDLE;
            prog_grp_r <= '0;
         end else begin
            case (seq_r)
               SEQ_IDLE: begin
                  if (pend_r != '0) begin
                     prog_grp_r <= pend_r;
                     seq_r <= SEQ_PROG;
                  end
               end
               SEQ_PROG: begin
                  if (prog_done_in) begin
                     prog_grp_r <= '0;
                     seq_r <= SEQ_IDLE;
                  end
               end
               default: seq_r <= SEQ_IDLE;
            endcase
         end
      end
   end

   assign prog_req_out = (seq_r == SEQ_PROG);
   assign prog_grp_out = prog_grp_r;

   // Pending programming requests; new requests win over the clear when the idle sequencer takes them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= '0;
      end else if (pce) begin
         if (hr) begin
            pend_r <= '0;
         end else begin
            pend_r <= (pend_r & ~(seq_r == SEQ_IDLE ? pend_r : '0))
                      | trig_fall
                      | {NUM_GRP{mains_rise || hr_rel
                                 || cmd_prog_all}};
         end
      end
   end

   // Group on state: auto turn-on after programming, host commands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grp_on_r <= '0;
      end else if (pce) begin
         if (hr || mains_fall) begin
            grp_on_r <= '0;
         end else begin
            grp_on_r <= (grp_on_r & ~trig_rise & ~cmd_off)
                        | cmd_on
                        | (prog_done && ctrl_r[CTRL_AUTO] ?
                           prog_grp_r : '0);
         end
      end
   end

   // Programming status: completion sets, release or mains clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pstat_r <= '0;
      end else if (pce) begin
         if (hr) begin
            pstat_r <= '0;
         end else if (mains_fall || trig_rise != '0) begin
            pstat_r <= prog_done ? prog_grp_r : '0;
         end else if (prog_done) begin
            pstat_r <= pstat_r | prog_grp_r;
         end
      end
   end

   // Run-time counter store request on mains or shutdown assertion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nvm_r <= 1'b0;
      end else if (pce) begin
         nvm_r <= mains_fall;
      end
   end

   assign nvm_store_out = nvm_r;
   assign pg_out = '0;
   assign pg_oe_n = pg_oe_n_r;
   assign front_end_enable_out = ctrl_r[CTRL_FE];
   assign crowbar_trigger_out = crow_ev.act;

   inh_force_a: assert property (@(posedge pclk) disable iff (!presetn)
      pce && (inh_force != '0) |=> (pg_oe_n & $past(inh_force)) == '0)
      else $error("inhibited group not pulled low");
   mains_all_a: assert property (@(posedge pclk) disable iff (!presetn)
      pce && mains_act |=> pg_oe_n == '0)
      else $error("mains loss did not force all groups");
   trig_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      pce && trig_rise != '0 |=> (grp_on_r & $past(trig_rise)) == '0)
      else $error("released trigger left group on");
   pstat_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      pce && mains_fall && !prog_done |=> pstat_r == '0)
      else $error("programming status not cleared");
   nvm_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pce && mains_fall |=> nvm_store_out ##1 !nvm_store_out || !pce)
      else $error("store request not a single pulse");
   mains_prog_a: assert property (@(posedge pclk) disable iff (!presetn)
      pce && mains_rise && !hr |=> pend_r == '1)
      else $error("mains release did not request programming");
   auto_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      pce && prog_done && ctrl_r[CTRL_AUTO] && !hr && !mains_fall
      |=> (grp_on_r & $past(prog_grp_r)) == $past(prog_grp_r))
      else $error("auto turn-on missing after programming");
   hr_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      pce && hr |=> grp_on_r == '0 && pg_oe_n == '0)
      else $error("hard reset left a group on");
   crow_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(crowbar_trigger_out) |-> $past(ctrl_r[CTRL_CROW]))
      else $error("crowbar fired while disabled");
endmodule : gisc_top
`default_nettype wire

// ---- dv/gisc_pol_model.sv ----
// Converter groups on shared power-good lines and programming engine
`timescale 1ns/1ps
`default_nettype none
module gisc_conv_model
   import gisc_pkg::*;
#(
   parameter int RAMP = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [NUM_GRP-1:0] pg_oe_n,
   input wire logic [NUM_GRP-1:0] pg_out,
   output logic [NUM_GRP-1:0] pg_line,
   input wire logic prog_req,
   input wire logic [7:0] dly,
   output logic prog_done,
   output logic [NUM_GRP-1:0] conv_on
);
   logic [NUM_GRP-1:0] on_r;
   logic [7:0] ramp_r [NUM_GRP];
   logic [7:0] cnt_r;
   logic seen_r;
   logic done_r;
   // Pull-up lifts a released line; converters only listen
   assign pg_line = pg_oe_n | pg_out;
   assign conv_on = on_r;
   assign prog_done = done_r;
   // Outputs ramp for RAMP cycles before following the line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_r <= '0;
         for (int g = 0; g < NUM_GRP; g++) begin
            ramp_r[g] <= 8'h00;
         end
      end else begin
         for (int g = 0; g < NUM_GRP; g++) begin
            if (pg_line[g] == on_r[g]) begin
               ramp_r[g] <= 8'h00;
            end else if (ramp_r[g] == 8'(RAMP - 1)) begin
               on_r[g] <= pg_line[g];
               ramp_r[g] <= 8'h00;
            end else begin
               ramp_r[g] <= ramp_r[g] + 8'h01;
            end
         end
      end
   end
   // Engine answers once per request after dly cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 8'h00;
         seen_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (!prog_req) begin
            cnt_r <= 8'h00;
            seen_r <= 1'b0;
         end else if (!seen_r && cnt_r >= dly) begin
            done_r <= 1'b1;
            seen_r <= 1'b1;
         end else if (!seen_r) begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end
endmodule : gisc_conv_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the group inhibit and shutdown block
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import gisc_pkg::*;
();
   localparam int MC = 20;
   localparam int CROW = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic mains_n, shut_n, hrst_n, req, done, nvm, crow_in, fe, crow_o;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NUM_INT-1:0] int_n;
   logic [NUM_GRP-1:0] pg_in, pg_oe_n, grp, conv, pg_o;
   logic [7:0] dly;
   int fail_count, cmp_count, nvm_cnt, n;

   gisc_top #(.MAINS_CYC(MC), .CROW_CYC(CROW)) i_dut (
      .pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .interrupt_in_n(int_n), .mains_loss_in_n(mains_n),
      .system_shutdown_in_n(shut_n), .hard_reset_in_n(hrst_n),
      .pg_in(pg_in), .pg_out(pg_o), .pg_oe_n(pg_oe_n), .prog_req_out(req),
      .prog_grp_out(grp), .prog_done_in(done), .nvm_store_out(nvm),
      .crowbar_event_in(crow_in), .front_end_enable_out(fe),
      .crowbar_trigger_out(crow_o)
   );
   gisc_conv_model i_conv (
      .pclk(pclk), .presetn(presetn), .pg_oe_n(pg_oe_n), .pg_out(pg_o),
      .pg_line(pg_in), .prog_req(req), .dly(dly), .prog_done(done),
      .conv_on(conv)
   );
   // Clock generator
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Counts run-time counter store pulses
   always @(posedge pclk) begin
      if (nvm === 1'b1) nvm_cnt++;
   end
   task final_report();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   function logic inw(int v, int lo, int hi);
      return (v >= lo) && (v <= hi);
   endfunction : inw
   function logic cnd(int sel, logic [3:0] e);
      case (sel)
         0: return pg_oe_n === e;
         1: return req === 1'b1;
         default: return crow_o === e[0];
      endcase
   endfunction : cnd
   // Bounded wait; n holds the edges it took
   task wt(input int sel, input logic [3:0] e, input int lim);
      logic ok;
      n = 0;
      ok = cnd(sel, e);
      while (!ok && n < lim) begin
         @(posedge pclk);
         n++;
         ok = cnd(sel, e);
      end
      chk("wait", 1, {31'h0, ok});
      if (!ok) final_report();
   endtask : wt
   // One APB transfer; read data and error land in rd and er
   task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 1, {31'h0, pready});
      if (pready !== 1'b1) final_report();
   endtask : apb
   task t_reset();
      apb(1'b0, CTRL_OFF, 32'h0);
      chk("ctrl", {29'h0, CTRL_RST}, rd);
      chk("fe", 1, {31'h0, fe});
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped", 1, {31'h0, er});
      apb(1'b0, PSTAT_OFF, 32'h0);
      chk("pstat_rst", 0, rd);
   endtask : t_reset
   task t_inhibit();
      logic ok;
      apb(1'b1, MAP_OFF, 32'h15);
      apb(1'b1, CTRL_OFF, 32'h3);
      apb(1'b1, CMD_OFF, 32'h200);
      wt(0, 4'hf, 40);
      @(posedge pclk);
      int_n <= 4'he;
      wt(0, 4'ha, INH_LAT_CYC + 20);
      ok = inw(n, INH_LAT_CYC - 2, INH_LAT_CYC + 6);
      chk("inh_lat", 1, {31'h0, ok});
      apb(1'b1, CMD_OFF, 32'h200);
      wt(1, 4'h0, 10);
      chk("grp", 32'hf, {28'h0, grp});
      repeat (20) @(posedge pclk);
      chk("pg", 32'ha, {28'h0, pg_oe_n});
      int_n <= 4'hc;
      repeat (INH_LAT_CYC + 10) @(posedge pclk);
      int_n <= 4'hd;
      wt(0, 4'he, 6);
      int_n <= 4'hf;
      wt(0, 4'hf, 6);
      repeat (12) @(posedge pclk);
      chk("conv", 32'hf, {28'h0, conv});
   endtask : t_inhibit
   task t_trigger();
      logic [3:0] m;
      dly <= 8'h28;
      for (int i = 0; i < NUM_INT; i++) begin
         m = 4'h1 << i;
         apb(1'b1, CMD_OFF, {24'h0, m, 4'h0});
         wt(0, ~m, 5);
         apb(1'b1, MODE_OFF, {28'h0, m});
         @(posedge pclk);
         int_n <= ~m;
         wt(1, 4'h0, INH_LAT_CYC + 10);
         chk("grp", {28'h0, m}, {28'h0, grp});
         wt(0, 4'hf, 80);
         apb(1'b0, PSTAT_OFF, 32'h0);
         chk("pstat_bit", 1, {31'h0, rd[i]});
         @(posedge pclk);
         int_n <= 4'hf;
         wt(0, ~m, 5);
         apb(1'b0, PSTAT_OFF, 32'h0);
         chk("pstat", 0, rd);
         apb(1'b1, CMD_OFF, {28'h0, m});
         wt(0, 4'hf, 5);
      end
   endtask : t_trigger
   task t_mains();
      int k;
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, CTRL_OFF, i ? 32'h2 : 32'h3);
         k = nvm_cnt;
         @(posedge pclk);
         if (i) shut_n <= 1'b0;
         else mains_n <= 1'b0;
         wt(0, 4'h0, MC + 10);
         chk("ml_lat", 1, {31'h0, inw(n, MC, MC + 4)});
         repeat (3) @(posedge pclk);
         chk("nvm", k + 1, nvm_cnt);
         apb(1'b0, PSTAT_OFF, 32'h0);
         chk("pstat", 0, rd);
         mains_n <= 1'b1;
         shut_n <= 1'b1;
         wt(1, 4'h0, 10);
         chk("grp", 32'hf, {28'h0, grp});
         repeat (60) @(posedge pclk);
         chk("pg", i ? 32'h0 : 32'hf, {28'h0, pg_oe_n});
         apb(1'b1, CMD_OFF, 32'hf);
         wt(0, 4'hf, 5);
      end
   endtask : t_mains
   task t_fe();
      apb(1'b1, CTRL_OFF, 32'h1);
      repeat (2) @(posedge pclk);
      chk("fe", 0, {31'h0, fe});
      apb(1'b1, CTRL_OFF, 32'h3);
      repeat (2) @(posedge pclk);
      chk("fe", 1, {31'h0, fe});
   endtask : t_fe
   task t_crow();
      @(posedge pclk);
      crow_in <= 1'b1;
      @(posedge pclk);
      crow_in <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("crow_off", 0, {31'h0, crow_o});
      apb(1'b1, CTRL_OFF, 32'h7);
      @(posedge pclk);
      crow_in <= 1'b1;
      @(posedge pclk);
      crow_in <= 1'b0;
      wt(2, 4'h1, 4);
      wt(2, 4'h0, CROW + 5);
      chk("crow_len", CROW, n);
      apb(1'b1, CMD_OFF, 32'h100);
      wt(2, 4'h1, 4);
      apb(1'b0, STAT_OFF, 32'h0);
      chk("status", 32'h4f0f, rd);
      wt(2, 4'h0, CROW + 5);
   endtask : t_crow
   task t_hard_reset();
      @(posedge pclk);
      hrst_n <= 1'b0;
      wt(0, 4'h0, 4);
      apb(1'b0, CTRL_OFF, 32'h0);
      chk("hr_err", 1, {31'h0, er});
      @(posedge pclk);
      hrst_n <= 1'b1;
      wt(1, 4'h0, 8);
      chk("grp", 32'hf, {28'h0, grp});
      repeat (60) @(posedge pclk);
      chk("pg", 0, {28'h0, pg_oe_n});
      apb(1'b0, CTRL_OFF, 32'h0);
      chk("ctrl", {29'h0, CTRL_RST}, rd);
   endtask : t_hard_reset
   // Reset, then the scenarios in order
   initial begin
      {presetn, psel, penable, pwrite, crow_in} = 5'h00;
      {mains_n, shut_n, hrst_n} = 3'h7;
      paddr = '0;
      pwdata = '0;
      int_n = '1;
      dly = 8'h03;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_inhibit();
      t_trigger();
      t_mains();
      t_fe();
      t_crow();
      t_hard_reset();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
